// ---- rtl/ieie_pkg.sv ----
// Shared constants, types and error-correction functions of the serial EEPROM engine.
package ieie_pkg;

    // ========================================================================
    // Geometry
    localparam int ADDR_W     = 15;
    localparam int PAGE_W     = 6;
    localparam int GRP_BYTES  = 4;
    localparam int ECC_W      = 6;
    localparam int GRP_W      = 8 * GRP_BYTES;
    localparam int FIFO_DEPTH = 8;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // ========================================================================
    // Select byte and command fields
    localparam logic [3:0] ARRAY_TYPE_DEF = 4'h5;  // Arbitrary value.
    localparam logic [3:0] ID_TYPE_DEF    = 4'h6;  // Arbitrary value.
    localparam int LOCK_SEL_POS  = 2;  // Bit ten of the address, in the high byte.
    localparam int LOCK_DATA_POS = 1;

    // ========================================================================
    // Timing
    localparam int CLK_FREQ_HZ     = 40_000_000;
    localparam int WRITE_TIME_US   = 5;
    localparam int WRITE_CYCLES    = WRITE_TIME_US * (CLK_FREQ_HZ / 1_000_000);

    // ========================================================================
    // Types
    typedef struct packed {
        logic [ECC_W-1:0] chk;
        logic [GRP_W-1:0] data;
    } ieie_grp_t;

    typedef struct packed {
        logic [PAGE_W-1:0] off;
        logic [7:0]        data;
    } ieie_wbyte_t;

    typedef enum {PH_IDLE, PH_DEV, PH_AHI, PH_ALO, PH_WDAT, PH_RDAT} ieie_phase_t;
    typedef enum {WE_IDLE, WE_DRAIN, WE_GROUP, WE_WAIT} ieie_weng_t;

    // ========================================================================
    // Hamming check bits over one group; data bits sit at non-power-of-two positions.
    function automatic logic [ECC_W-1:0] ecc_gen(input logic [GRP_W-1:0] d);
        int k;
        ecc_gen = '0;
        k = 0;
        for (int p = 1; p < GRP_W + ECC_W + 1; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (d[k]) ecc_gen = ecc_gen ^ ECC_W'(p);
                k++;
            end
        end
    endfunction : ecc_gen

    function automatic logic [GRP_W-1:0] ecc_fix(input ieie_grp_t g);
        logic [ECC_W-1:0] syn;
        int k;
        syn = g.chk ^ ecc_gen(g.data);
        ecc_fix = g.data;
        k = 0;
        for (int p = 1; p < GRP_W + ECC_W + 1; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (syn == ECC_W'(p)) ecc_fix[k] = ~g.data[k];
                k++;
            end
        end
    endfunction : ecc_fix

endpackage : ieie_pkg

// ---- rtl/ieie_engine.sv ----
// Serial EEPROM slave: bus decoding, write-byte FIFO, page buffer and protected array.
// Operation
// [RQ1] Write: select, high then low address, acknowledged.
// [RQ2] Write cycle only on stop after data acknowledge.
// [RQ3] After cycle, counter points past last byte.
// [RQ4] Busy: data line released, bus ignored.
// [RQ5] Protect high: data refused, nothing written.
// [RQ6] Page write wraps inside 64-byte page.
// [RQ7] ID page write: bit ten zero, offset.
// [RQ8] Locked ID page: data bytes refused.
// [RQ9] Lock command sets permanent read-only lock; rst_i clears id_locked_o here.
// [RQ10] Reads correct single bit per group.
// [RQ11] Partial group write rewrites whole group.
// [RQ12] Select acknowledged only after cycle ends.
// [RQ13] Master reuses polling select upper bits.
// [RQ14] Reads ignore the protect input.
// [RQ15] Master no-acknowledge ends read, standby.
// [RQ16] Random read: dummy write, restart, read.
// [RQ17] Current read returns counter byte, increments.
// [RQ18] One counter shared by array, ID page.
// [RQ19] Sequential read wraps to address zero.
// [RQ20] ID page read uses offset bits.
// [RQ21] Lock status: data acknowledge if unlocked.
// [RQ22] Start discards pending command.
// [RQ23] Respond only when chip enables match.
// [RQ24] Protect high: select, address still acknowledged.
// [RQ25] Direction bit one reads, zero writes.
// [RQ26] Write cycle lasts configurable clock count.
`timescale 1ns/1ps

// ============================================================================
// Write-byte FIFO
module ieie_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             rst_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW:0]      wr_ptr;
    logic [PW:0]      rd_ptr;
    logic             push;
    logic             pop;

    assign out_valid_o = (wr_ptr != rd_ptr);
    assign in_ready_o  = (wr_ptr != {~rd_ptr[PW], rd_ptr[PW-1:0]});
    assign out_data_o  = store[rd_ptr[PW-1:0]];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            store[wr_ptr[PW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule : ieie_fifo

// ============================================================================
// Top
module ieie_engine
    import ieie_pkg::*;
#(
    parameter int         AW           = ADDR_W,
    parameter logic [3:0] ARRAY_TYPE   = ARRAY_TYPE_DEF,
    parameter logic [3:0] ID_TYPE      = ID_TYPE_DEF,
    parameter int         WR_CYCLES    = WRITE_CYCLES
) (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // Serial bus
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    // Straps and status
    input  wire logic       write_protect_i,
    input  wire logic [2:0] chip_enable_i,
    output logic            write_busy_o,
    output logic            id_locked_o
);
    localparam int GN = AW - 2;
    localparam int PG = AW - PAGE_W;
    localparam int GI = PAGE_W - 2;

    // ========================================================================
    // Pin synchronisers
    logic       scl_m, scl_s, scl_q, sda_m, sda_s, sda_q, wp_m, wp_s;
    logic [2:0] ce_m, ce_s;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            {scl_m, scl_s, scl_q, sda_m, sda_s, sda_q} <= 6'h3F;
            {wp_m, wp_s} <= 2'h0;
            ce_m <= 3'h0;
            ce_s <= 3'h0;
        end else begin
            {scl_m, scl_s, scl_q} <= {scl_i, scl_m, scl_s};
            {sda_m, sda_s, sda_q} <= {sda_i, sda_m, sda_s};
            {wp_m, wp_s} <= {write_protect_i, wp_m};
            ce_m <= chip_enable_i;
            ce_s <= ce_m;
        end
    end

    logic scl_rise, scl_fall, start_ev, stop_ev;
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_ev  = scl_s & scl_q & ~sda_q & sda_s;

    // ========================================================================
    // Shared state
    ieie_phase_t       phase;
    ieie_weng_t        we_st;
    logic [3:0]        cnt;
    logic [7:0]        sh, tx, ahi;
    logic              ack_slot, idsel, lock_sel, rd_first, mack;
    logic              data_seen, lock_pend, wr_go, we_done, eng_busy;
    logic [AW-1:0]     addr;
    logic [PG-1:0]     wpage;
    logic [PAGE_W-1:0] woff, wr_last;
    logic [GI-1:0]     grp;
    logic [63:0]       pmask;
    logic [31:0]       wcnt;
    logic              f_in_v, f_in_r, f_out_v, f_out_r;
    ieie_wbyte_t       f_in_d, f_out_d;

    ieie_grp_t mem   [2**GN];
    ieie_grp_t idmem [2**GI];
    logic [7:0] pbuf [2**PAGE_W];

    assign eng_busy = (we_st != WE_IDLE) | wr_go;

    // Reads take the corrected group, so a single flipped cell never reaches the bus.
    ieie_grp_t       rd_grp;
    logic [GRP_W-1:0] rd_fix;
    logic [7:0]       rd_byte;
    assign rd_grp  = idsel ? idmem[addr[PAGE_W-1:2]] : mem[addr[AW-1:2]]; // [RQ18] [RQ20]
    assign rd_fix  = ecc_fix(rd_grp); // [RQ10]
    assign rd_byte = rd_fix[{addr[1:0], 3'h0} +: 8];

    logic wr_ok;
    always_comb begin
        wr_ok = ~wp_s; // [RQ5]
        if (idsel) begin
            wr_ok = wr_ok & ~id_locked_o; // [RQ8] [RQ21]
            if (lock_sel) wr_ok = wr_ok & sh[LOCK_DATA_POS]; // [RQ9]
            else wr_ok = wr_ok & f_in_r;
        end else begin
            wr_ok = wr_ok & f_in_r;
        end
    end

    // ========================================================================
    // Bus protocol
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase <= PH_IDLE;
            cnt <= 4'h0;
            sh <= 8'h00;
            tx <= 8'h00;
            ahi <= 8'h00;
            ack_slot <= 1'b0;
            idsel <= 1'b0;
            lock_sel <= 1'b0;
            rd_first <= 1'b0;
            mack <= 1'b0;
            data_seen <= 1'b0;
            lock_pend <= 1'b0;
            wr_go <= 1'b0;
            addr <= '0;
            wpage <= '0;
            woff <= '0;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            f_in_v <= 1'b0;
            f_in_d <= '0;
        end else begin
            wr_go <= 1'b0;
            f_in_v <= 1'b0;
            sda_o <= 1'b0;
            if (we_done) begin
                addr <= {wpage, PAGE_W'(wr_last + 1'b1)}; // [RQ3]
            end
            if (eng_busy) begin
                phase <= PH_IDLE; // [RQ4] [RQ12]
                sda_oe_o <= 1'b0;
            end else if (start_ev) begin
                phase <= PH_DEV; // [RQ22]
                cnt <= 4'h0;
                ack_slot <= 1'b0;
                sda_oe_o <= 1'b0;
                data_seen <= 1'b0;
                lock_pend <= 1'b0;
            end else if (stop_ev) begin
                // The tenth slot: its rising edge has just been counted.
                if (phase == PH_WDAT && cnt == 4'h1 && !ack_slot && data_seen) begin
                    wr_go <= 1'b1; // [RQ2]
                end
                phase <= PH_IDLE;
                sda_oe_o <= 1'b0;
            end else if (phase == PH_IDLE) begin
                sda_oe_o <= 1'b0;
            end else if (scl_rise) begin
                if (cnt < 4'h8) begin
                    sh <= {sh[6:0], sda_s};
                    cnt <= cnt + 4'h1;
                end else begin
                    mack <= ~sda_s; // [RQ15]
                end
            end else if (scl_fall) begin
                if (ack_slot) begin
                    ack_slot <= 1'b0;
                    cnt <= 4'h0;
                    sda_oe_o <= 1'b0;
                    if (phase == PH_RDAT) begin
                        rd_first <= 1'b0;
                        if (rd_first || mack) begin
                            tx <= rd_byte; // [RQ17] [RQ14]
                            sda_oe_o <= ~rd_byte[7];
                            addr <= addr + 1'b1; // [RQ19]
                        end else begin
                            phase <= PH_IDLE; // [RQ15]
                        end
                    end
                end else if (cnt == 4'h8) begin
                    ack_slot <= 1'b1;
                    sda_oe_o <= 1'b0;
                    case (phase)
                        PH_DEV: begin
                            if ((sh[7:4] == ARRAY_TYPE || sh[7:4] == ID_TYPE)
                                && sh[3:1] == ce_s) begin // [RQ23]
                                sda_oe_o <= 1'b1;
                                idsel <= (sh[7:4] == ID_TYPE);
                                if (sh[0]) begin
                                    phase <= PH_RDAT; // [RQ16] [RQ25]
                                    rd_first <= 1'b1;
                                end else begin
                                    phase <= PH_AHI; // [RQ1]
                                end
                            end else begin
                                phase <= PH_IDLE;
                                ack_slot <= 1'b0;
                            end
                        end
                        PH_AHI: begin
                            ahi <= sh;
                            sda_oe_o <= 1'b1; // [RQ1] [RQ24]
                            phase <= PH_ALO;
                        end
                        PH_ALO: begin
                            sda_oe_o <= 1'b1; // [RQ24]
                            phase <= PH_WDAT;
                            woff <= sh[PAGE_W-1:0];
                            if (idsel) begin
                                addr <= AW'(sh[PAGE_W-1:0]); // [RQ18] [RQ20]
                                wpage <= '0;
                                lock_sel <= ahi[LOCK_SEL_POS]; // [RQ7] [RQ9]
                            end else begin
                                addr <= AW'({ahi, sh});
                                wpage <= PG'({ahi, sh} >> PAGE_W); // [RQ6]
                                lock_sel <= 1'b0;
                            end
                        end
                        PH_WDAT: begin
                            sda_oe_o <= wr_ok; // [RQ5] [RQ8] [RQ21]
                            if (wr_ok) begin
                                data_seen <= 1'b1;
                                if (idsel && lock_sel) begin
                                    lock_pend <= 1'b1; // [RQ9]
                                end else begin
                                    f_in_v <= 1'b1;
                                    f_in_d <= '{off: woff, data: sh};
                                    woff <= woff + 1'b1; // [RQ6]
                                end
                            end
                        end
                        PH_RDAT: begin
                            sda_oe_o <= 1'b0;
                        end
                        default: begin
                            phase <= PH_IDLE;
                        end
                    endcase
                end else if (phase == PH_RDAT && cnt != 4'h0) begin
                    sda_oe_o <= ~tx[3'h7 - cnt[2:0]];
                end
            end
        end
    end

    // ========================================================================
    // Write FIFO between the bus and the page buffer
    ieie_fifo #(
        .WIDTH ($bits(ieie_wbyte_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (f_in_v),
        .in_ready_o  (f_in_r),
        .in_data_i   (f_in_d),
        .out_valid_o (f_out_v),
        .out_ready_i (f_out_r),
        .out_data_o  (f_out_d)
    );

    // The drain stalls while the array is being programmed; a full FIFO refuses data.
    assign f_out_r = (we_st == WE_IDLE) | (we_st == WE_DRAIN);

    // ========================================================================
    // Group read-modify-write
    ieie_grp_t        tgt_old;
    logic [GRP_W-1:0] tgt_new;
    logic [3:0]       tgt_msk;
    assign tgt_old = idsel ? idmem[grp] : mem[{wpage, grp}];
    assign tgt_msk = pmask[{grp, 2'h0} +: 4];

    always_comb begin
        tgt_new = ecc_fix(tgt_old); // [RQ11]
        for (int b = 0; b < GRP_BYTES; b++) begin
            if (tgt_msk[b]) tgt_new[8*b +: 8] = pbuf[{grp, 2'(b)}];
        end
    end

    initial begin
        for (int i = 0; i < 2**GN; i++) mem[i] = '{ecc_gen({GRP_BYTES{ERASED_BYTE}}),
                                                  {GRP_BYTES{ERASED_BYTE}}};
        for (int i = 0; i < 2**GI; i++) idmem[i] = '{ecc_gen({GRP_BYTES{ERASED_BYTE}}),
                                                    {GRP_BYTES{ERASED_BYTE}}};
    end

    // Plain always: the erased-state initial block also writes mem and idmem.
    always @(posedge ref_clk_i) begin
        if (f_out_v && f_out_r) begin
            pbuf[f_out_d.off] <= f_out_d.data;
        end
        if (we_st == WE_GROUP && tgt_msk != 4'h0) begin
            if (idsel) idmem[grp] <= '{ecc_gen(tgt_new), tgt_new}; // [RQ11] [RQ7]
            else mem[{wpage, grp}] <= '{ecc_gen(tgt_new), tgt_new};
        end
    end

    // ========================================================================
    // Internal write cycle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            we_st <= WE_IDLE;
            grp <= '0;
            wcnt <= 32'h0;
            pmask <= 64'h0;
            wr_last <= '0;
            we_done <= 1'b0;
            id_locked_o <= 1'b0;
            write_busy_o <= 1'b0;
        end else begin
            we_done <= 1'b0;
            write_busy_o <= eng_busy;
            if (f_out_v && f_out_r) begin
                pmask[f_out_d.off] <= 1'b1;
                wr_last <= f_out_d.off;
            end
            case (we_st)
                WE_IDLE: begin
                    if (start_ev && !wr_go) pmask <= 64'h0; // [RQ22]
                    if (wr_go) we_st <= WE_DRAIN;
                end
                WE_DRAIN: begin
                    if (!f_out_v) begin
                        grp <= '0;
                        we_st <= WE_GROUP;
                        if (lock_pend) id_locked_o <= 1'b1; // [RQ9]
                    end
                end
                WE_GROUP: begin
                    grp <= grp + 1'b1;
                    if (grp == GI'(2**GI - 1)) begin
                        we_st <= WE_WAIT;
                        wcnt <= 32'h0;
                    end
                end
                WE_WAIT: begin
                    wcnt <= wcnt + 32'h1;
                    if (wcnt >= 32'(WR_CYCLES - 1)) begin // [RQ26]
                        we_st <= WE_IDLE;
                        we_done <= 1'b1;
                        pmask <= 64'h0;
                    end
                end
                default: begin
                    we_st <= WE_IDLE;
                end
            endcase
        end
    end
endmodule : ieie_engine

// ---- tb/ieie_engine_chk.sv ----
// Assertion checker watching the ports of the serial EEPROM engine.
`timescale 1ns/1ps

// ==========
// Checker
module ieie_engine_chk #(
    parameter int WR_CYCLES = 200
) (
    // Clock and reset
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    // Bus, straps and status
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic       write_protect_i,
    input wire logic [2:0] chip_enable_i,
    input wire logic       write_busy_o,
    input wire logic       id_locked_o
);
    logic [3:0]  since_stop;
    logic [15:0] busy_len;
    logic        sda_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // Saturates, so a long idle gap never wraps back into the window.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sda_q      <= 1'b1;
            since_stop <= 4'hF;
        end else begin
            sda_q <= sda_i;
            if (scl_i && sda_i && !sda_q) since_stop <= 4'h0;
            else if (since_stop != 4'hF) since_stop <= since_stop + 4'h1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) busy_len <= 16'h0000;
        else if (write_busy_o) busy_len <= busy_len + 16'h0001;
        else busy_len <= 16'h0000;
    end

    sequence s_busy_go;
        $rose(write_busy_o);
    endsequence

    property p_od_low;
        sda_oe_o |-> !sda_o;
    endproperty
    a_od_low: assert property (p_od_low) else $error("sda driven high");

    property p_busy_quiet;
        write_busy_o |-> !sda_oe_o;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");

    property p_poll_nack;
        $rose(sda_oe_o) |-> !write_busy_o && !$past(write_busy_o);
    endproperty
    a_poll_nack: assert property (p_poll_nack) else $error("ack while busy");

    property p_lock_sticky;
        id_locked_o |=> id_locked_o;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock lost");

    property p_busy_min;
        $fell(write_busy_o) |-> busy_len >= WR_CYCLES;
    endproperty
    a_busy_min: assert property (p_busy_min) else $error("write cycle short");

    property p_busy_max;
        s_busy_go |-> ##[1:1000] !write_busy_o;
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("write cycle hung");

    property p_busy_cause;
        s_busy_go |-> since_stop < 4'hC;
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("cycle without stop");

    property p_wp_hold;
        write_protect_i && $past(write_protect_i, 8) |-> !$rose(write_busy_o);
    endproperty
    a_wp_hold: assert property (p_wp_hold) else $error("cycle while protected");
endmodule : ieie_engine_chk

bind ieie_engine ieie_engine_chk #(.WR_CYCLES(WR_CYCLES)) u_chk (
    .ref_clk_i, .rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
    .write_protect_i, .chip_enable_i, .write_busy_o, .id_locked_o
);

// ---- tb/ieie_master.sv ----
// Bus master model that clocks and drives the engine's serial bus.
`timescale 1ns/1ps

// ==========
// Master
module ieie_master (
    // Clock
    input  wire logic ref_clk_i,
    // Bus
    input  wire logic sda_oe_i,
    output logic      scl_o,
    output logic      sda_o
);
    logic sda_m;

    // Open drain: with both sides released the pull-up holds the line high.
    assign sda_o = sda_m & ~sda_oe_i;

    initial begin
        scl_o = 1'b1;
        sda_m = 1'b1;
    end

    // The bus clock is 8 system clocks and stands high between frames.
    task q(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : q

    task start();
        sda_m <= 1'b1;
        q(4);
        scl_o <= 1'b1;
        q(3);
        sda_m <= 1'b0;
        q(3);
        scl_o <= 1'b0;
        q(1);
    endtask : start

    task stop();
        sda_m <= 1'b0;
        q(4);
        scl_o <= 1'b1;
        q(3);
        sda_m <= 1'b1;
        q(4);
    endtask : stop

    // Low for 5 clocks so the device's late release settles before the rise.
    task bit_io(input logic b, output logic r);
        sda_m <= b;
        q(4);
        scl_o <= 1'b1;
        q(2);
        #1;
        r = sda_o;
        q(1);
        scl_o <= 1'b0;
        q(1);
    endtask : bit_io

    task wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : wbyte

    task rbyte(output logic [7:0] d, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!ack, r);
    endtask : rbyte
endmodule : ieie_master

// ---- tb/ieie_engine_tb_top.sv ----
// Self-checking bench of the serial EEPROM engine.
`timescale 1ns/1ps

// ==========
// Bench
module ieie_engine_tb_top;
    import ieie_pkg::*;

    localparam logic [2:0] CE = 3'h5;
    localparam logic [3:0] AT = ARRAY_TYPE_DEF;
    localparam logic [3:0] IT = ID_TYPE_DEF;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic        wp;
        logic        ack;
        logic [7:0]  rdv;
    } ieie_row_t;

    logic       clk;
    logic       rst;
    logic       wp;
    logic       scl;
    logic       sda;
    logic       oe;
    logic       busy;
    logic       locked;
    logic [7:0] d;
    logic       k;
    int         n;
    int         mismatches;
    int         checks_done;
    ieie_row_t  rows [3];

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ieie_master m (.ref_clk_i(clk), .sda_oe_i(oe), .scl_o(scl), .sda_o(sda));

    ieie_engine #(.WR_CYCLES(200)) dut (
        .ref_clk_i      (clk),
        .rst_i          (rst),
        .scl_i          (scl),
        .sda_i          (sda),
        .sda_o          (),
        .sda_oe_o       (oe),
        .write_protect_i(wp),
        .chip_enable_i  (CE),
        .write_busy_o   (busy),
        .id_locked_o    (locked)
    );

    task chk8(input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk8

    task chk1(input logic e, input logic g);
        chk8({7'h00, e}, {7'h00, g});
    endtask : chk1

    task final_report();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    task sel(input logic [3:0] t, input logic rd, output logic a);
        m.start();
        m.wbyte({t, CE, rd}, a);
    endtask : sel

    task adr(input logic [15:0] a);
        logic g;
        m.wbyte(a[15:8], g);
        chk1(1'b1, g);
        m.wbyte(a[7:0], g);
        chk1(1'b1, g);
    endtask : adr

    task wr(input logic [3:0] t, input logic [15:0] a, input logic [7:0] v,
            input int cnt, input logic e);
        logic g;
        sel(t, 1'b0, g);
        chk1(1'b1, g);
        adr(a);
        for (int i = 0; i < cnt; i++) begin
            m.wbyte(v + 8'(i), g);
            chk1(e, g);
        end
        m.stop();
    endtask : wr

    // The acknowledged select byte is left open as the next instruction.
    task poll(input logic [3:0] t);
        logic a;
        n = 0;
        a = 1'b0;
        while (a !== 1'b1 && n < 40) begin
            sel(t, 1'b0, a);
            if (a !== 1'b1) begin
                m.stop();
                n++;
            end
        end
        if (a !== 1'b1) begin
            mismatches++;
            final_report();
        end
    endtask : poll

    task rdr(input logic [3:0] t, input logic [15:0] a);
        logic g;
        poll(t);
        adr(a);
        sel(t, 1'b1, g);
        chk1(1'b1, g);
    endtask : rdr

    initial begin
        mismatches  = 0;
        checks_done = 0;
        rst = 1'b1;
        wp  = 1'b0;
        rows[0] = '{16'h0123, 8'h5A, 1'b0, 1'b1, 8'h5A};
        rows[1] = '{16'h0124, 8'hC3, 1'b1, 1'b0, 8'hFF};
        rows[2] = '{16'h7FFF, 8'h11, 1'b0, 1'b1, 8'h11};
        repeat (9) @(posedge clk);
        chk1(1'b0, busy | locked | oe);
        @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        foreach (rows[i]) begin
            wp <= rows[i].wp;
            wr(AT, rows[i].addr, rows[i].data, 1, rows[i].ack);
            rdr(AT, rows[i].addr);
            chk1(rows[i].ack, n != 0);
            m.rbyte(d, 1'b0);
            m.stop();
            chk8(rows[i].rdv, d);
        end
        wr(AT, 16'h0122, 8'h3C, 1, 1'b1);
        poll(AT);
        m.stop();
        sel(AT, 1'b1, k);
        m.rbyte(d, 1'b0);
        m.stop();
        chk8(8'h5A, d);
        wr(AT, 16'h003F, 8'hA0, 2, 1'b1);
        rdr(AT, 16'h003F);
        m.rbyte(d, 1'b1);
        chk8(8'hA0, d);
        m.rbyte(d, 1'b0);
        m.stop();
        chk8(8'hFF, d);
        rdr(AT, 16'h0000);
        m.rbyte(d, 1'b0);
        m.stop();
        chk8(8'hA1, d);
        rdr(AT, 16'h7FFF);
        m.rbyte(d, 1'b1);
        chk8(8'h11, d);
        m.rbyte(d, 1'b0);
        m.stop();
        chk8(8'hA1, d);
        sel(AT, 1'b0, k);
        adr(16'h0200);
        m.wbyte(8'h00, k);
        repeat (4) m.bit_io(1'b0, k);
        m.stop();
        poll(AT);
        m.stop();
        chk1(1'b0, n != 0);
        m.start();
        m.wbyte({AT, ~CE, 1'b0}, k);
        m.stop();
        chk1(1'b0, k);
        wr(IT, 16'hF805, 8'h77, 1, 1'b1);
        rdr(IT, 16'h0005);
        m.rbyte(d, 1'b0);
        m.stop();
        chk8(8'h77, d);
        sel(IT, 1'b0, k);
        adr(16'h0000);
        m.wbyte(8'h00, k);
        chk1(1'b1, k);
        m.start();
        m.stop();
        poll(IT);
        m.stop();
        chk1(1'b0, n != 0);
        wr(IT, 16'h0400, 8'h02, 1, 1'b1);
        poll(IT);
        m.stop();
        chk1(1'b1, locked);
        wr(IT, 16'h0005, 8'h12, 1, 1'b0);
        rdr(IT, 16'h0005);
        m.rbyte(d, 1'b0);
        m.stop();
        chk8(8'h77, d);
        final_report();
    end
endmodule : ieie_engine_tb_top
